// File: tpm_pkg.sv
package tpm_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int              IDX_W          = 12;
  localparam int              BYTE_SHIFT     = 2;
  localparam int              MIN_ADDR_W     = IDX_W + BYTE_SHIFT;
  localparam logic [IDX_W-1:0] IDX_PAT_HIGH  = 12'h627;
  localparam logic [IDX_W-1:0] IDX_DA_LOW    = 12'h628;
  localparam logic [IDX_W-1:0] IDX_DA_MID    = 12'h629;
  localparam logic [IDX_W-1:0] IDX_DA_HIGH   = 12'h62a;
  localparam logic [IDX_W-1:0] IDX_SENT_LOW  = 12'h639;
  localparam logic [IDX_W-1:0] IDX_SENT_HIGH = 12'h63a;

  // ---------------------------------------------------------------
  // clearing sequence: three reads in this order
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CLR_FIRST  = 12'h60f;
  localparam logic [IDX_W-1:0] IDX_CLR_SECOND = 12'h610;
  localparam logic [IDX_W-1:0] IDX_CLR_THIRD  = 12'h611;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int          WORD_W    = 16;
  localparam int          CNT_W     = 32;
  localparam int          DA_W      = 48;
  localparam int          BUS_W     = 32;
  localparam int          SEL_W     = 4;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;
  localparam logic [31:0] BUS_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_FIRST = 2'b01,
    SEQ_SECND = 2'b11
  } tpm_seq_type;

endpackage : tpm_pkg

// File: tpm_seq_if.sv
`timescale 1ns/10ps
interface tpm_seq_if (
  input wire logic clk_sys,
  input wire logic reset
);
  import tpm_pkg::*;

  logic             acc_pulse;
  logic             acc_read;
  logic [IDX_W-1:0] acc_idx;
  logic             clear_q;

  modport watcher (
    input  clk_sys,
    input  reset,
    input  acc_pulse,
    input  acc_read,
    input  acc_idx,
    output clear_q
  );

  modport regs (
    output acc_pulse,
    output acc_read,
    output acc_idx,
    input  clear_q
  );
endinterface : tpm_seq_if

// File: tpm_clear_seq.sv
`timescale 1ns/10ps
module tpm_clear_seq
  import tpm_pkg::*;
(
  tpm_seq_if.watcher sq
);

  // ---------------------------------------------------------------
  // sequence decode
  // ---------------------------------------------------------------
  tpm_seq_type state_q;
  tpm_seq_type state_d;
  logic        clear_d;
  wire logic   rd_first  = sq.acc_read && (sq.acc_idx == IDX_CLR_FIRST);
  wire logic   rd_second = sq.acc_read && (sq.acc_idx == IDX_CLR_SECOND);
  wire logic   rd_third  = sq.acc_read && (sq.acc_idx == IDX_CLR_THIRD);

  // any other access restarts; a fresh first read re-arms
  always_comb begin
    state_d = state_q;
    clear_d = 1'b0;
    if (sq.acc_pulse) begin
      case (state_q)
        SEQ_IDLE:  state_d = rd_first ? SEQ_FIRST : SEQ_IDLE;
        SEQ_FIRST: state_d = rd_second ? SEQ_SECND : (rd_first ? SEQ_FIRST : SEQ_IDLE);
        SEQ_SECND: begin
          clear_d = rd_third;
          state_d = rd_first ? SEQ_FIRST : SEQ_IDLE;
        end
        default:   state_d = SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sq.clk_sys) begin
    if (sq.reset) begin
      state_q    <= SEQ_IDLE;
      sq.clear_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      sq.clear_q <= clear_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_third_clears: assert property (@(posedge sq.clk_sys) disable iff (sq.reset)
    (sq.acc_pulse && rd_third && state_q == SEQ_SECND) |=> sq.clear_q)
    else $error("third read of sequence did not clear");

  chk_break_no_clear: assert property (@(posedge sq.clk_sys) disable iff (sq.reset)
    (sq.acc_pulse && state_q != SEQ_SECND) |=> !sq.clear_q)
    else $error("clear without full sequence");

endmodule : tpm_clear_seq

// File: tpm_regs.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
// Overview of operation
// - bits 47:32 of the test pattern sit in a read/write register reset to zero.
// - bits 15:0 of the perfect-match value are read/write and feed the address compare.
// - bits 31:16 of the perfect-match value sit in their own read/write register reset to zero.
// - bits 47:32 of the perfect-match value sit in a third read/write register reset to zero.
// - a 32-bit sent-packet counter shows its low half in a register reset to zero.
// - the counter's high half is shown in a second register reset to zero.
// - reading 0x60f, 0x610 and 0x611 in that order clears the sent-packet counter.
module tpm_regs
  import tpm_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [SEL_W-1:0]  wb_sel_i,
  input  wire logic [BUS_W-1:0]  wb_dat_i,
  output logic      [BUS_W-1:0]  wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              tx_pkt_sent,
  input  wire logic              da_check,
  input  wire logic [DA_W-1:0]   da_value,
  output logic      [WORD_W-1:0] test_pattern_high,
  output logic      [DA_W-1:0]   da_match_value,
  output logic                   da_match_hit
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (ADDR_W < MIN_ADDR_W) begin : g_bad_addr_w
    $error("ADDR_W too small for the register map");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [WORD_W-1:0] lane_merge(
    input logic [WORD_W-1:0] old_val,
    input logic [BUS_W-1:0]  new_val,
    input logic [SEL_W-1:0]  sel
  );
    logic [WORD_W-1:0] res;
    res       = old_val;
    if (sel[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (sel[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction : lane_merge

  function automatic logic [BUS_W-1:0] word_out(input logic [WORD_W-1:0] w);
    return {16'h0000, w};
  endfunction : word_out

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic                  ack_q;
  logic [BUS_W-1:0]      rdat_q;
  logic [BUS_W-1:0]      rdat_d;
  wire logic             acc_take  = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic [IDX_W-1:0] idx       = wb_adr_i[IDX_W+BYTE_SHIFT-1:BYTE_SHIFT];
  wire logic             upper_ok  = (wb_adr_i >> MIN_ADDR_W) == '0;
  wire logic             wr_take   = acc_take && wb_we_i && upper_ok;
  wire logic             hit_pat   = upper_ok && (idx == IDX_PAT_HIGH);
  wire logic             hit_da_lo = upper_ok && (idx == IDX_DA_LOW);
  wire logic             hit_da_md = upper_ok && (idx == IDX_DA_MID);
  wire logic             hit_da_hi = upper_ok && (idx == IDX_DA_HIGH);
  wire logic             hit_sn_lo = upper_ok && (idx == IDX_SENT_LOW);
  wire logic             hit_sn_hi = upper_ok && (idx == IDX_SENT_HIGH);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] pat_high_q;
  logic [WORD_W-1:0] da_low_q;
  logic [WORD_W-1:0] da_mid_q;
  logic [WORD_W-1:0] da_high_q;
  logic [CNT_W-1:0]  sent_cnt_q;
  logic [CNT_W-1:0]  sent_cnt_d;
  logic              match_q;
  logic [DA_W-1:0]   match_ref;

  assign match_ref = {da_high_q, da_mid_q, da_low_q};

  // ---------------------------------------------------------------
  // clearing sequence watcher
  // ---------------------------------------------------------------
  tpm_seq_if u_seq_if (
    .clk_sys (clk_sys),
    .reset   (reset)
  );

  assign u_seq_if.acc_pulse = acc_take;
  assign u_seq_if.acc_read  = !wb_we_i && upper_ok;
  assign u_seq_if.acc_idx   = idx;

  tpm_clear_seq u_clear_seq (
    .sq (u_seq_if.watcher)
  );

  // clear restarts the count; a packet in the same cycle still counts
  always_comb begin
    sent_cnt_d = sent_cnt_q;
    if (u_seq_if.clear_q) begin
      sent_cnt_d = RST_COUNT;
    end
    if (tx_pkt_sent) begin
      sent_cnt_d = sent_cnt_d + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdat_d = BUS_ZERO;
    if (hit_pat) begin
      rdat_d = word_out(pat_high_q);
    end else if (hit_da_lo) begin
      rdat_d = word_out(da_low_q);
    end else if (hit_da_md) begin
      rdat_d = word_out(da_mid_q);
    end else if (hit_da_hi) begin
      rdat_d = word_out(da_high_q);
    end else if (hit_sn_lo) begin
      rdat_d = word_out(sent_cnt_q[15:0]);
    end else if (hit_sn_hi) begin
      rdat_d = word_out(sent_cnt_q[31:16]);
    end
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_q  <= 1'b0;
      rdat_q <= BUS_ZERO;
    end else begin
      ack_q  <= acc_take;
      rdat_q <= acc_take ? rdat_d : BUS_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pat_high_q <= RST_WORD;
      da_low_q   <= RST_WORD;
      da_mid_q   <= RST_WORD;
      da_high_q  <= RST_WORD;
    end else begin
      if (wr_take && hit_pat) begin
        pat_high_q <= lane_merge(pat_high_q, wb_dat_i, wb_sel_i);
      end
      if (wr_take && hit_da_lo) begin
        da_low_q <= lane_merge(da_low_q, wb_dat_i, wb_sel_i);
      end
      if (wr_take && hit_da_md) begin
        da_mid_q <= lane_merge(da_mid_q, wb_dat_i, wb_sel_i);
      end
      if (wr_take && hit_da_hi) begin
        da_high_q <= lane_merge(da_high_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ---------------------------------------------------------------
  // counter and address compare
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sent_cnt_q <= RST_COUNT;
      match_q    <= 1'b0;
    end else begin
      sent_cnt_q <= sent_cnt_d;
      if (da_check) begin
        match_q <= (da_value == match_ref);
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_o          = ack_q;
  assign wb_dat_o          = rdat_q;
  assign test_pattern_high = pat_high_q;
  assign da_match_value    = match_ref;
  assign da_match_hit      = match_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_pat_write_lands: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_take && hit_pat && wb_sel_i[1:0] == 2'b11)
      |=> (pat_high_q == $past(wb_dat_i[15:0])))
    else $error("pattern high write not stored");

  chk_da_compare: assert property (@(posedge clk_sys) disable iff (reset)
    da_check |=> (match_q == ($past(da_value) == $past(match_ref))))
    else $error("address match result wrong");

  chk_da_mid_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset && !(wr_take && hit_da_md)) |=> $stable(da_mid_q))
    else $error("match mid word changed without write");

  chk_da_high_write: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_take && hit_da_hi && wb_sel_i[1:0] == 2'b11)
      |=> (da_high_q == $past(wb_dat_i[15:0])))
    else $error("match high word write not stored");

  chk_cnt_counts: assert property (@(posedge clk_sys) disable iff (reset)
    (tx_pkt_sent && !u_seq_if.clear_q) |=> (sent_cnt_q == $past(sent_cnt_q) + 32'h0000_0001))
    else $error("sent counter did not advance");

  chk_cnt_high_read: assert property (@(posedge clk_sys) disable iff (reset)
    (acc_take && !wb_we_i && hit_sn_hi)
      |=> (wb_ack_o && wb_dat_o[15:0] == $past(sent_cnt_q[31:16])))
    else $error("counter high half read wrong");

  chk_cnt_clear: assert property (@(posedge clk_sys) disable iff (reset)
    (u_seq_if.clear_q && !tx_pkt_sent) |=> (sent_cnt_q == RST_COUNT))
    else $error("counter not cleared after sequence");

  chk_cnt_ro: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset && !u_seq_if.clear_q && !tx_pkt_sent) |=> $stable(sent_cnt_q))
    else $error("counter moved without cause");

  chk_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  chk_pat_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset && !(wr_take && hit_pat))
      |=> $stable(pat_high_q))
    else $error("pattern high word changed without write");

  chk_da_low_write: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_take && hit_da_lo && wb_sel_i[1:0] == 2'b11)
      |=> (da_low_q == $past(wb_dat_i[15:0])))
    else $error("match low word write not stored");

  chk_da_low_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset && !(wr_take && hit_da_lo))
      |=> $stable(da_low_q))
    else $error("match low word changed without write");

  chk_da_mid_write: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_take && hit_da_md && wb_sel_i[1:0] == 2'b11)
      |=> (da_mid_q == $past(wb_dat_i[15:0])))
    else $error("match mid word write not stored");

  chk_da_high_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset && !(wr_take && hit_da_hi))
      |=> $stable(da_high_q))
    else $error("match high word changed without write");

  chk_match_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset && !da_check)
      |=> $stable(match_q))
    else $error("match result changed without compare");

  chk_cnt_low_read: assert property (@(posedge clk_sys) disable iff (reset)
    (acc_take && !wb_we_i && hit_sn_lo)
      |=> (wb_ack_o && wb_dat_o[15:0] == $past(sent_cnt_q[15:0])))
    else $error("counter low half read wrong");

  chk_clear_with_pkt: assert property (@(posedge clk_sys) disable iff (reset)
    (u_seq_if.clear_q && tx_pkt_sent)
      |=> (sent_cnt_q == RST_COUNT + 32'h0000_0001))
    else $error("packet lost at counter clear");

  chk_ack_after_take: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset && acc_take)
      |=> wb_ack_o)
    else $error("request not acknowledged in one cycle");

  chk_idle_data_zero: assert property (@(posedge clk_sys) disable iff (reset)
    !wb_ack_o
      |-> (wb_dat_o == BUS_ZERO))
    else $error("read data not zero outside ack");

  chk_upper_half_zero: assert property (@(posedge clk_sys) disable iff (reset)
    wb_ack_o
      |-> (wb_dat_o[31:16] == 16'h0000))
    else $error("upper half of read data not zero");

endmodule : tpm_regs

// File: test_pattern_match_tx_counter_tb.sv
`timescale 1ns/10ps
module test_pattern_match_tx_counter_tb;
  import tpm_pkg::*;

  localparam int ADDR_W  = 14;
  localparam int MAX_CYC = 90000;

  logic              clk_sys;
  logic              reset;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic              wb_we_i;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [SEL_W-1:0]  wb_sel_i;
  logic [BUS_W-1:0]  wb_dat_i;
  logic [BUS_W-1:0]  wb_dat_o;
  logic              wb_ack_o;
  logic              tx_pkt_sent;
  logic              da_check;
  logic [DA_W-1:0]   da_value;
  logic [WORD_W-1:0] test_pattern_high;
  logic [DA_W-1:0]   da_match_value;
  logic              da_match_hit;
  int                n_mismatch = 0;
  int                checks     = 0;
  int                cyc_cnt    = 0;

  tpm_regs #(.ADDR_W(ADDR_W)) u_dut (
    .clk_sys           (clk_sys),
    .reset             (reset),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_we_i           (wb_we_i),
    .wb_adr_i          (wb_adr_i),
    .wb_sel_i          (wb_sel_i),
    .wb_dat_i          (wb_dat_i),
    .wb_dat_o          (wb_dat_o),
    .wb_ack_o          (wb_ack_o),
    .tx_pkt_sent       (tx_pkt_sent),
    .da_check          (da_check),
    .da_value          (da_value),
    .test_pattern_high (test_pattern_high),
    .da_match_value    (da_match_value),
    .da_match_hit      (da_match_hit)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == MAX_CYC) begin
      n_mismatch++;
      $display("mismatch at %0t: timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wb_access(input logic we, input logic [IDX_W-1:0] idx,
                           input logic [WORD_W-1:0] wdat, input logic [SEL_W-1:0] sel,
                           output logic [BUS_W-1:0] rdat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {16'h0000, wdat};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      $display("mismatch at %0t: no ack", $time);
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_access

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [WORD_W-1:0] d,
                    input logic [SEL_W-1:0] sel);
    logic [BUS_W-1:0] dummy;
    wb_access(1'b1, idx, d, sel, dummy);
  endtask : wr

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [WORD_W-1:0] exp,
                        input string what);
    logic [BUS_W-1:0] got;
    wb_access(1'b0, idx, 16'h0000, 4'h3, got);
    chk(got, {16'h0000, exp}, what);
  endtask : rd_chk

  task automatic pulses(input int n);
    repeat (n) @(posedge clk_sys) tx_pkt_sent <= 1'b1;
    @(posedge clk_sys) tx_pkt_sent <= 1'b0;
    @(posedge clk_sys);
  endtask : pulses

  task automatic compare(input logic [DA_W-1:0] v, input logic exp);
    @(posedge clk_sys);
    da_check <= 1'b1;
    da_value <= v;
    @(posedge clk_sys) da_check <= 1'b0;
    @(posedge clk_sys);
    chk({31'h0000_0000, da_match_hit}, {31'h0000_0000, exp}, "match hit");
  endtask : compare

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, tx_pkt_sent, da_check} = 5'b0_0000;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    da_value = 48'h0000_0000_0000;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(IDX_PAT_HIGH, 16'h0000, "pattern reset");
    rd_chk(IDX_DA_LOW, 16'h0000, "match low reset");
    rd_chk(IDX_DA_MID, 16'h0000, "match mid reset");
    rd_chk(IDX_DA_HIGH, 16'h0000, "match high reset");
    rd_chk(IDX_SENT_LOW, 16'h0000, "count low reset");
    rd_chk(IDX_SENT_HIGH, 16'h0000, "count high reset");
    $display("test reset values done");
    wr(IDX_PAT_HIGH, 16'hffff, 4'h3);
    wr(IDX_PAT_HIGH, 16'h1234, 4'h1);
    rd_chk(IDX_PAT_HIGH, 16'hff34, "pattern lane");
    chk({16'h0000, test_pattern_high}, 32'h0000_ff34, "pattern out");
    wr(IDX_DA_LOW, 16'h9abc, 4'h3);
    wr(IDX_DA_MID, 16'h5678, 4'h3);
    wr(IDX_DA_HIGH, 16'h1234, 4'h3);
    wr(12'h700, 16'h5555, 4'h3);
    rd_chk(12'h700, 16'h0000, "unmapped");
    rd_chk(IDX_DA_LOW, 16'h9abc, "match low");
    rd_chk(IDX_DA_MID, 16'h5678, "match mid");
    rd_chk(IDX_DA_HIGH, 16'h1234, "match high");
    chk(da_match_value[47:16], 32'h1234_5678, "match out");
    chk(da_match_value[31:0], 32'h5678_9abc, "match out low");
    compare(48'h1234_5678_9abc, 1'b1);
    compare(48'h1234_5678_9abd, 1'b0);
    $display("test pattern and match done");
    pulses(65537);
    wr(IDX_SENT_LOW, 16'hbeef, 4'h3);
    rd_chk(IDX_SENT_LOW, 16'h0001, "count low");
    rd_chk(IDX_SENT_HIGH, 16'h0001, "count high");
    $display("test counter done");
    // interrupted sequences must leave the count
    rd_chk(IDX_CLR_FIRST, 16'h0000, "seq read");
    rd_chk(IDX_CLR_SECOND, 16'h0000, "seq read");
    wr(IDX_DA_LOW, 16'h9abc, 4'h3);
    rd_chk(IDX_CLR_THIRD, 16'h0000, "seq read");
    rd_chk(IDX_CLR_FIRST, 16'h0000, "seq read");
    rd_chk(IDX_DA_MID, 16'h5678, "between");
    rd_chk(IDX_CLR_SECOND, 16'h0000, "seq read");
    rd_chk(IDX_CLR_THIRD, 16'h0000, "seq read");
    rd_chk(IDX_SENT_LOW, 16'h0001, "no clear low");
    rd_chk(IDX_SENT_HIGH, 16'h0001, "no clear high");
    $display("test broken sequence done");
    rd_chk(IDX_CLR_FIRST, 16'h0000, "seq read");
    rd_chk(IDX_CLR_FIRST, 16'h0000, "seq read");
    rd_chk(IDX_CLR_SECOND, 16'h0000, "seq read");
    rd_chk(IDX_CLR_THIRD, 16'h0000, "seq read");
    rd_chk(IDX_SENT_LOW, 16'h0000, "clear low");
    rd_chk(IDX_SENT_HIGH, 16'h0000, "clear high");
    pulses(3);
    rd_chk(IDX_SENT_LOW, 16'h0003, "recount");
    rd_chk(IDX_CLR_FIRST, 16'h0000, "seq read");
    rd_chk(IDX_CLR_SECOND, 16'h0000, "seq read");
    fork
      rd_chk(IDX_CLR_THIRD, 16'h0000, "seq read");
      begin
        repeat (2) @(posedge clk_sys);
        tx_pkt_sent <= 1'b1;
        @(posedge clk_sys) tx_pkt_sent <= 1'b0;
      end
    join
    rd_chk(IDX_SENT_LOW, 16'h0001, "clear with packet");
    $display("test clear sequence done");
    compare(48'h1234_5678_9abc, 1'b1);
    @(posedge clk_sys) reset <= 1'b1;
    @(posedge clk_sys) reset <= 1'b0;
    rd_chk(IDX_PAT_HIGH, 16'h0000, "pattern rereset");
    rd_chk(IDX_DA_MID, 16'h0000, "match mid rereset");
    rd_chk(IDX_SENT_LOW, 16'h0000, "count rereset");
    chk({31'h0000_0000, da_match_hit}, 32'h0000_0000, "hit rereset");
    $display("test second reset done");
    end_sim();
  end

endmodule : test_pattern_match_tx_counter_tb
